//--- hw/word_aligner.sv
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// manual-mode receive word aligner with AXI4-Lite settings
module word_aligner (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // deserializer stream
  input  wire logic [9:0]  rxWord,
  input  wire logic        rxValid,
  // user alignment enable
  input  wire logic        alignEnable,
  // aligned stream
  output logic [9:0]       alignedWord,
  output logic             alignedValid,
  output logic             syncStatus,
  output logic             patternDetect,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // register state
  logic                       wideQ,   wideD;
  logic                       len7Q,   len7D;
  logic [15:0]                patQ,    patD;
  logic                       awHeldQ, awHeldD;
  logic [3:0]                 awAddrQ, awAddrD;
  logic                       wHeldQ,  wHeldD;
  logic [31:0]                wDataQ,  wDataD;
  logic [3:0]                 wStrbQ,  wStrbD;
  logic                       bValidQ, bValidD;
  logic [1:0]                 bRespQ,  bRespD;
  logic                       rValidQ, rValidD;
  logic [31:0]                rDataQ,  rDataD;
  logic [1:0]                 rRespQ,  rRespD;

  // datapath state
  logic [31:0]                histQ,    histD;
  logic [3:0]                 slipQ,    slipD;
  logic                       enPrevQ,  enPrevD;
  logic                       armedQ,   armedD;
  logic                       syncQ,    syncD;
  logic                       detQ,     detD;
  logic [9:0]                 outQ,     outD;
  logic                       outVldQ,  outVldD;

  word_align_pkg::align_cfg_t cfg;
  logic                       hit;
  logic [3:0]                 hitSlip;
  logic                       doWrite;
  logic [31:0]                statusWord;

  assign cfg = '{wide: wideQ, len7: len7Q, pattern: patQ};
  assign doWrite = awHeldQ && wHeldQ && !bValidQ;
  assign statusWord = {26'h0, slipQ, detQ, syncQ};

  // pattern search over history
  pattern_match u_match (
    .hist (histQ),
    .cfg  (cfg),
    .hit  (hit),
    .slip (hitSlip)
  );

  // axi slave next state
  always_comb begin
    wideD   = wideQ;
    len7D   = len7Q;
    patD    = patQ;
    awHeldD = awHeldQ;
    awAddrD = awAddrQ;
    wHeldD  = wHeldQ;
    wDataD  = wDataQ;
    wStrbD  = wStrbQ;
    bValidD = bValidQ;
    bRespD  = bRespQ;
    rValidD = rValidQ;
    rDataD  = rDataQ;
    rRespD  = rRespQ;
    if (s_axi_awvalid && !awHeldQ) begin
      awHeldD = 1'b1;
      awAddrD = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeldQ) begin
      wHeldD = 1'b1;
      wDataD = s_axi_wdata;
      wStrbD = s_axi_wstrb;
    end
    if (doWrite) begin
      awHeldD = 1'b0;
      wHeldD  = 1'b0;
      bValidD = 1'b1;
      bRespD  = word_align_pkg::RESP_OKAY;
      unique case (awAddrQ)
        word_align_pkg::CTRL_ADDR: begin
          if (wStrbQ[0]) begin
            wideD = wDataQ[word_align_pkg::CTRL_WIDE_BIT]; // RL2
            len7D = wDataQ[word_align_pkg::CTRL_LEN7_BIT]; // RL2
          end
        end
        word_align_pkg::PATTERN_ADDR: begin
          if (wStrbQ[0]) patD[7:0]  = wDataQ[7:0];
          if (wStrbQ[1]) patD[15:8] = wDataQ[15:8];
        end
        word_align_pkg::STATUS_ADDR: ;
        default: bRespD = word_align_pkg::RESP_SLVERR;
      endcase
    end
    if (bValidQ && s_axi_bready) bValidD = 1'b0;
    if (s_axi_arvalid && !rValidQ) begin
      rValidD = 1'b1;
      rRespD  = word_align_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        word_align_pkg::CTRL_ADDR:    rDataD = {30'h0, len7Q, wideQ};
        word_align_pkg::PATTERN_ADDR: rDataD = {16'h0, patQ};
        word_align_pkg::STATUS_ADDR:  rDataD = statusWord;
        default: begin
          rDataD = 32'h0000_0000;
          rRespD = word_align_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rValidQ && s_axi_rready) begin
      rValidD = 1'b0;
    end
  end

  // axi slave registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wideQ   <= word_align_pkg::CTRL_RESET[word_align_pkg::CTRL_WIDE_BIT];
      len7Q   <= word_align_pkg::CTRL_RESET[word_align_pkg::CTRL_LEN7_BIT];
      patQ    <= word_align_pkg::PATTERN_RESET;
      awHeldQ <= 1'b0;
      awAddrQ <= 4'h0;
      wHeldQ  <= 1'b0;
      wDataQ  <= 32'h0000_0000;
      wStrbQ  <= 4'h0;
      bValidQ <= 1'b0;
      bRespQ  <= 2'h0;
      rValidQ <= 1'b0;
      rDataQ  <= 32'h0000_0000;
      rRespQ  <= 2'h0;
    end else begin
      wideQ   <= wideD;
      len7Q   <= len7D;
      patQ    <= patD;
      awHeldQ <= awHeldD;
      awAddrQ <= awAddrD;
      wHeldQ  <= wHeldD;
      wDataQ  <= wDataD;
      wStrbQ  <= wStrbD;
      bValidQ <= bValidD;
      bRespQ  <= bRespD;
      rValidQ <= rValidD;
      rDataQ  <= rDataD;
      rRespQ  <= rRespD;
    end
  end

  // alignment next state
  always_comb begin
    logic rise;
    logic searching;
    logic [31:0] shifted;
    rise      = alignEnable && !enPrevQ; // RL4
    searching = 1'b0;
    shifted   = histQ;
    histD     = histQ;
    slipD     = slipQ;
    armedD    = armedQ;
    syncD     = syncQ;
    detD      = 1'b0;
    outD      = outQ;
    outVldD   = 1'b0;
    enPrevD   = alignEnable;
    // rising edge arms an 8-bit search
    if (!wideQ && rise) armedD = 1'b1; // RL5 RL7
    if (wideQ) armedD = 1'b0;
    if (rxValid) begin
      // newest word enters at the top of the window
      if (wideQ) shifted = {rxWord, histQ[31:10]};
      else shifted = {rxWord[7:0], histQ[31:8]};
      histD = shifted;
      outVldD = 1'b1;
      if (wideQ) outD = histQ[slipQ +: 10];
      else outD = {2'b00, histQ[slipQ +: 8]};
      // search is governed by edge or level
      searching = wideQ ? alignEnable : (armedQ || (!wideQ && rise)); // RL3 RL8 RL10
      if (hit && searching) begin // RL1
        detD  = 1'b1;
        syncD = 1'b1;
        if (hitSlip != slipQ) slipD = hitSlip; // RL6
        if (!wideQ) armedD = 1'b0; // RL7
      end
    end
  end

  // alignment registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      histQ   <= 32'h0000_0000; // RL11
      slipQ   <= 4'h0; // RL11
      enPrevQ <= 1'b1; // RL11
      armedQ  <= 1'b0; // RL11
      syncQ   <= 1'b0;
      detQ    <= 1'b0;
      outQ    <= 10'h000;
      outVldQ <= 1'b0;
    end else begin
      histQ   <= histD;
      slipQ   <= slipD;
      enPrevQ <= enPrevD;
      armedQ  <= armedD;
      syncQ   <= syncD;
      detQ    <= detD;
      outQ    <= outD;
      outVldQ <= outVldD;
    end
  end

  // outputs from flops
  assign alignedWord   = outQ;
  assign alignedValid  = outVldQ;
  assign syncStatus    = syncQ;
  assign patternDetect = detQ;
  assign s_axi_awready = !awHeldQ;
  assign s_axi_wready  = !wHeldQ;
  assign s_axi_bvalid  = bValidQ;
  assign s_axi_bresp   = bRespQ;
  assign s_axi_arready = !rValidQ;
  assign s_axi_rvalid  = rValidQ;
  assign s_axi_rdata   = rDataQ;
  assign s_axi_rresp   = rRespQ;

endmodule // word_aligner

//--- hw/word_align_pkg.sv
// Functional notes
// RL1 - Find word boundary in deserializer words by matching the programmed alignment pattern.
// RL2 - 8-bit width uses 16-bit pattern; 10-bit width uses 7- or 10-bit pattern.
// RL3 - In manual mode the alignment enable input governs searching at both widths.
// RL4 - At 8-bit width only rising edges of alignment enable matter.
// RL5 - 8-bit: a rising edge after reset release starts a pattern search.
// RL6 - Pattern found at a new boundary during search moves the boundary there.
// RL7 - 8-bit: once aligned, realign only after a fresh rising edge of enable.
// RL8 - At 10-bit width the enable level, not its edges, governs searching.
// RL9 - 10-bit: while enable high, match the pattern or its bitwise complement.
// RL10 - 10-bit: while enable low, keep the current boundary regardless of pattern.
// RL11 - Reset clears boundary and edge history; no search until reset released.
// RL12 - Controlling logic drives alignment enable synchronous to the parallel clock.
package word_align_pkg;

  // register map, byte addresses
  localparam logic [3:0] CTRL_ADDR    = 4'h0;
  localparam logic [3:0] PATTERN_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR  = 4'h8;

  // control field positions
  localparam int CTRL_WIDE_BIT  = 0;
  localparam int CTRL_LEN7_BIT  = 1;
  localparam int CTRL_ALIGN_BIT = 2;

  // reset values
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // datapath sizes
  localparam int WORD_W   = 10;
  localparam int HIST_W   = 32;
  localparam int SLIP_W   = 4;
  localparam int NARROW_W = 8;
  localparam int PAT16_W  = 16;
  localparam int PAT10_W  = 10;
  localparam int PAT7_W   = 7;

  // alignment settings carried as one bundle
  typedef struct packed {
    logic        wide;
    logic        len7;
    logic [15:0] pattern;
  } align_cfg_t;

endpackage

//--- hw/pattern_match.sv
`timescale 1ns/1ps
// finds the lowest slip at which the pattern sits in the history window
module pattern_match (
  // history and settings
  input  wire logic [31:0]              hist,
  input  wire word_align_pkg::align_cfg_t cfg,
  // result
  output logic                          hit,
  output logic [3:0]                    slip
);

  logic [9:0] hitVec;

  // one comparator per candidate slip
  genvar s;
  generate
    for (s = 0; s < 10; s++) begin : g_slip
      always_comb begin
        logic [15:0] seg;
        seg = hist[s +: 16];
        if (!cfg.wide) begin
          hitVec[s] = (s < 8) && (seg == cfg.pattern);
        end else if (cfg.len7) begin
          hitVec[s] = (seg[6:0] == cfg.pattern[6:0]) ||
                      (seg[6:0] == ~cfg.pattern[6:0]); // RL9
        end else begin
          hitVec[s] = (seg[9:0] == cfg.pattern[9:0]) ||
                      (seg[9:0] == ~cfg.pattern[9:0]); // RL9
        end
      end
    end
  endgenerate

  // priority pick of lowest slip
  always_comb begin
    hit  = 1'b0;
    slip = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (hitVec[i]) begin
        hit  = 1'b1;
        slip = 4'(i);
      end
    end
  end

endmodule // pattern_match

//--- sim/word_aligner_assertions.sv
`timescale 1ns/1ps
// watches the aligner ports for stream and alignment timing
module word_aligner_assertions (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // stream and enable
  input wire logic        rxValid,
  input wire logic        alignEnable,
  input wire logic [9:0]  alignedWord,
  input wire logic        alignedValid,
  input wire logic        syncStatus,
  input wire logic        patternDetect,
  // settings writes
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready
);
  logic wideQ, wideD, prevQ, armQ, armD, armNow;
  // width setting and search arming seen from outside
  always_comb begin
    wideD = wideQ;
    if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 4'h0 && s_axi_wstrb[0]) wideD = s_axi_wdata[0];
    armNow = armQ || (alignEnable && !prevQ);
    armD = (armQ && !patternDetect) || (alignEnable && !prevQ);
  end
  // history regs, enable history resets high
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wideQ <= 1'b0;
      prevQ <= 1'b1;
      armQ <= 1'b0;
    end else begin
      wideQ <= wideD;
      prevQ <= alignEnable;
      armQ <= armD;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_valid_follows: assert property (rxValid |=> alignedValid)
    else $error("accepted word not passed on");
  a_valid_only: assert property (!rxValid |=> !alignedValid)
    else $error("output word without input word");
  a_detect_sync: assert property (patternDetect |-> ##[0:1] syncStatus)
    else $error("match did not set sync");
  a_sync_sticky: assert property (syncStatus |=> syncStatus)
    else $error("sync dropped without reset");
  a_reset_clear: assert property (disable iff (1'b0) !reset_n |=>
    !syncStatus && !patternDetect && !alignedValid) else $error("reset left state");
  a_level_gate: assert property (patternDetect && wideQ |-> $past(alignEnable))
    else $error("wide match with enable low");
  a_edge_gate: assert property (patternDetect && !wideQ |-> $past(armNow))
    else $error("narrow match without rising enable");
  a_narrow_upper: assert property (alignedValid && !wideQ |-> alignedWord[9:8] == 2'h0)
    else $error("narrow word upper bits set");
endmodule // word_aligner_assertions

//--- sim/deser_model.sv
`timescale 1ns/1ps
// deserializer and enable source facing the aligner
module deser_model (
  // clock
  input wire logic  sys_clk,
  // stream and enable
  output logic [9:0] rxWord,
  output logic       rxValid,
  output logic       alignEnable
);
  // quiet bus at start
  initial begin
    rxWord = 10'h000;
    rxValid = 1'b0;
    alignEnable = 1'b0;
  end
  // one word after a random gap of scrambled idle cycles
  task automatic send(input logic [9:0] w);
    repeat ($urandom_range(2)) begin
      rxValid <= 1'b0;
      rxWord <= 10'($urandom);
      @(posedge sys_clk);
    end
    rxValid <= 1'b1;
    rxWord <= w;
    @(posedge sys_clk);
  endtask
  task automatic idle();
    rxValid <= 1'b0;
    rxWord <= 10'($urandom);
    @(posedge sys_clk);
  endtask
  // enable moves only after a clock edge
  task automatic setEnable(input logic v);
    alignEnable <= v;
    @(posedge sys_clk);
  endtask
endmodule // deser_model

//--- sim/test_word_aligner.sv
`timescale 1ns/1ps
module test_word_aligner;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [9:0]  rxWord, alignedWord;
  logic        rxValid, alignEnable, alignedValid, syncStatus, patternDetect, s;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [9:0]  want;
  int          seen;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [65:0] notes[$];
  logic [65:0] n;
  int          errors, num_checks, cyc, hits;
  always #12.5 sys_clk = ~sys_clk;
  word_aligner uut (.*);
  deser_model gen (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus transfer: w high writes, note holds {resp, mask, data}
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [1:0] r);
    logic ta, tw, td;
    notes.push_back({r, m, d});
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= w ? 4'hF : 4'($urandom);
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(negedge sys_clk);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      td = w ? s_axi_bvalid : s_axi_rvalid;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!td);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // pattern words between zero fillers, reports any detect pulse
  task automatic burst(input logic [19:0] p, input int k);
    hits = 0;
    seen = 0;
    want = p[9:0];
    repeat (3) gen.send(10'h000);
    gen.send(p[9:0]);
    if (k == 2) gen.send(p[19:10]);
    repeat (4) gen.send(10'h000);
    gen.idle();
    repeat (3) @(posedge sys_clk);
    s = (hits != 0);
  endtask
  // answer checker and detect counter on settled values
  always @(negedge sys_clk) begin
    if (patternDetect) hits++;
    if (alignedValid && alignedWord === want) seen++;
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      n = notes.pop_front();
      check({30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, n[65:64]});
      if (s_axi_rvalid) check(s_axi_rdata & n[63:32], n[31:0]);
    end
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    s_axi_awaddr <= 4'h0;
    s_axi_araddr <= 4'h0;
    s_axi_wstrb <= 4'hF;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    want = 10'h000;
    void'($urandom(32'h70C8));
    gen.setEnable(1'b1);
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    bus(0, word_align_pkg::CTRL_ADDR, 32'h0, 32'hFFFFFFFF, 2'h0);
    bus(0, word_align_pkg::PATTERN_ADDR, 32'h0, 32'hFFFF, 2'h0);
    bus(0, word_align_pkg::STATUS_ADDR, 32'h0, 32'h1, 2'h0);
    bus(0, 4'hC, 32'h0, 32'h0, word_align_pkg::RESP_SLVERR);
    bus(1, 4'hC, 32'h0, 32'h0, word_align_pkg::RESP_SLVERR);
    bus(1, word_align_pkg::PATTERN_ADDR, 32'hA5C3, 32'h0, 2'h0);
    burst({10'h0A5, 10'h0C3}, 2);
    check({31'h0, s}, 32'h0);
    gen.setEnable(1'b0);
    gen.setEnable(1'b1);
    burst({10'h0A5, 10'h0C3}, 2);
    check({31'h0, s}, 32'h1);
    bus(0, word_align_pkg::STATUS_ADDR, 32'h1, 32'h1, 2'h0);
    burst({10'h0A5, 10'h0C3}, 2);
    check({31'h0, s}, 32'h0);
    bus(1, word_align_pkg::CTRL_ADDR, 32'h1, 32'h0, 2'h0);
    bus(1, word_align_pkg::PATTERN_ADDR, 32'h17C, 32'h0, 2'h0);
    gen.setEnable(1'b0);
    burst(20'h0017C, 1);
    check({31'h0, s}, 32'h0);
    gen.setEnable(1'b1);
    burst(20'h0017C, 1);
    check({31'h0, s}, 32'h1);
    burst(20'h00283, 1);
    check({31'h0, s}, 32'h1);
    check(32'(seen != 0), 32'h1);
    bus(1, word_align_pkg::CTRL_ADDR, 32'h3, 32'h0, 2'h0);
    bus(1, word_align_pkg::PATTERN_ADDR, 32'h7C, 32'h0, 2'h0);
    burst(20'h0007C, 1);
    check({31'h0, s}, 32'h1);
    check(32'(seen != 0), 32'h1);
    bus(0, word_align_pkg::STATUS_ADDR, 32'h9, 32'h3D, 2'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    bus(0, word_align_pkg::STATUS_ADDR, 32'h0, 32'h1, 2'h0);
    bus(0, word_align_pkg::CTRL_ADDR, 32'h0, 32'hFFFFFFFF, 2'h0);
    end_sim();
  end
endmodule // test_word_aligner
bind word_aligner word_aligner_assertions chk (.*);
